// file: exec_core.sv
`timescale 1ns/1ps
// Behaviour
// - rotate right through carry: old carry to bit 7, bit 0 to carry; Z,C,N,V.
// - arithmetic shift right keeps bit 7, bit 0 to carry; Z,C,N,V; one cycle.
// - each status flag has its own one-cycle force-one and force-zero operation.
// - half-carry force-one takes one cycle and touches only that flag.
// - half-carry force-zero takes one cycle and leaves other flags alone.
// - bit-to-transfer-flag copies a register bit into the transfer flag only.
// - transfer-flag-to-bit copies the transfer flag into a register bit, no flags.
// - load with post-increment reads at pointer, then pointer plus one; two cycles.
// - load with pre-decrement subtracts one first, reads at new address; two cycles.
// - displaced load reads at Y or Z plus displacement, pointer unchanged.
// - direct load reads at the address in the instruction; two cycles, no flags.
// - store with post-increment writes at pointer, then pointer plus one.
// - store with pre-decrement subtracts one, then writes at new address.
module exec_core
    import exec_pkg::*;
#(
    parameter int PADDR_W = 8
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output dm_req_t                 dm_req,
    input  wire logic [7:0]         dm_rdata
);
    if (PADDR_W < 8)
    begin : g_paddr_check
        $error("PADDR_W must be at least 8");
    end

    exec_state_t state_r;
    instr_t      ir_r;
    logic [7:0]  rf_r [32];
    logic [7:0]  flags_r;
    logic        err_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    dm_req_t     dm_req_r;
    logic [4:0]  load_dst_r;

    logic [7:0]  addr8;
    logic        hit;
    logic        apb_acc;
    logic        apb_wr;
    logic [31:0] rd_mux;

    logic [7:0]  rd_val;
    logic [7:0]  rr_val;
    logic [2:0]  bsel;
    logic [4:0]  ptr_lo;
    logic [4:0]  ptr_hi;
    logic [15:0] ptr_val;
    logic [15:0] ptr_nxt;
    logic [15:0] mem_addr;
    logic        is_load;
    logic        is_store;
    logic        ptr_ok;
    logic        legal;
    logic        upd_ptr;
    logic [4:0]  pair_d;
    logic [4:0]  pair_s;

    logic [7:0]  alu_res;
    logic        alu_c;
    logic        alu_z;
    logic        alu_n;
    logic        alu_v;

    // register bus slave
    assign addr8   = paddr[7:0];
    assign hit     = (addr8 == OFS_INSTR) || (addr8 == OFS_STATUS) ||
                     (addr8[7] && (addr8[1:0] == 2'b00));
    assign apb_acc = psel && penable && pready_r;
    assign apb_wr  = apb_acc && pwrite && hit;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;
    assign dm_req  = dm_req_r;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (addr8 == OFS_INSTR)
            rd_mux = ir_r;
        else if (addr8 == OFS_STATUS)
            rd_mux = {22'h0, err_r, (state_r != S_IDLE), flags_r};
        else if (addr8[7] && (addr8[1:0] == 2'b00))
            rd_mux = {24'h0, rf_r[addr8[6:2]]};
    end

    // answer only while idle, so software never races the execution unit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= PRDATA_RESET;
        end
        else if (psel && penable && !pready_r && (state_r == S_IDLE))
        begin
            pready_r  <= 1'b1;
            pslverr_r <= !hit;
            prdata_r  <= (pwrite || !hit) ? 32'h0000_0000 : rd_mux;
        end
        else
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // operand and address decode
    assign rd_val = rf_r[ir_r.rd];
    assign rr_val = rf_r[ir_r.rr];
    assign bsel   = ir_r.k[2:0];
    assign pair_d = {ir_r.rd[4:1], 1'b0};
    assign pair_s = {ir_r.rr[4:1], 1'b0};

    always_comb
    begin
        case (ir_r.k[9:8])
            2'd0:    ptr_lo = PTR_X_LO;
            2'd1:    ptr_lo = PTR_Y_LO;
            default: ptr_lo = PTR_Z_LO;
        endcase
    end

    assign ptr_hi  = ptr_lo + 5'd1;
    assign ptr_val = {rf_r[ptr_hi], rf_r[ptr_lo]};

    always_comb
    begin
        is_load  = 1'b0;
        is_store = 1'b0;
        ptr_ok   = (ir_r.k[9:8] != 2'd3);
        legal    = 1'b1;
        upd_ptr  = 1'b0;
        ptr_nxt  = ptr_val;
        mem_addr = ptr_val;
        case (ir_r.op)
            OP_POINTER_LOAD:
                is_load = 1'b1;
            OP_POINTER_LOAD_INC:
            begin
                is_load = 1'b1;
                upd_ptr = 1'b1;
                ptr_nxt = ptr_val + 16'h0001;
            end
            OP_POINTER_LOAD_DEC:
            begin
                is_load  = 1'b1;
                upd_ptr  = 1'b1;
                ptr_nxt  = ptr_val - 16'h0001;
                mem_addr = ptr_nxt;
            end
            OP_DISPLACED_POINTER_LOAD:
            begin
                is_load  = 1'b1;
                ptr_ok   = (ir_r.k[9:8] == 2'd1) || (ir_r.k[9:8] == 2'd2);
                mem_addr = ptr_val + {10'h000, ir_r.k[5:0]};
            end
            OP_DIRECT_MEMORY_LOAD:
            begin
                is_load  = 1'b1;
                ptr_ok   = 1'b1;
                mem_addr = ir_r.k;
            end
            OP_POINTER_STORE:
                is_store = 1'b1;
            OP_POINTER_STORE_INC:
            begin
                is_store = 1'b1;
                upd_ptr  = 1'b1;
                ptr_nxt  = ptr_val + 16'h0001;
            end
            OP_POINTER_STORE_DEC:
            begin
                is_store = 1'b1;
                upd_ptr  = 1'b1;
                ptr_nxt  = ptr_val - 16'h0001;
                mem_addr = ptr_nxt;
            end
            OP_NOP, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_NIBBLE_SWAP,
            OP_FLAG_FORCE_ONE, OP_FLAG_FORCE_ZERO, OP_BIT_TO_TRANSFER_FLAG,
            OP_TRANSFER_FLAG_TO_BIT, OP_REGISTER_COPY, OP_REGISTER_PAIR_COPY,
            OP_IMMEDIATE_LOAD:
                ptr_ok = 1'b1;
            default:
                legal = 1'b0;
        endcase
        legal = legal && ptr_ok;
    end

    shift_bit_unit u_shift_bit_unit
    (
        .op   (ir_r.op),
        .val  (rd_val),
        .bsel (bsel),
        .cin  (flags_r[FLAG_C]),
        .tin  (flags_r[FLAG_T]),
        .res  (alu_res),
        .cout (alu_c),
        .zout (alu_z),
        .nout (alu_n),
        .vout (alu_v)
    );

    // sequencing: one cycle in exec, memory operations add a second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= S_IDLE;
            ir_r    <= '0;
        end
        else
        begin
            case (state_r)
                S_IDLE:
                    if (apb_wr && (addr8 == OFS_INSTR))
                    begin
                        ir_r    <= instr_t'(pwdata);
                        state_r <= S_EXEC;
                    end
                S_EXEC:  state_r <= (legal && (is_load || is_store)) ? S_MEM : S_IDLE;
                S_MEM:   state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_r <= 1'b0;
        else if ((state_r == S_EXEC) && !legal)
            err_r <= 1'b1;
        else if (apb_wr && (addr8 == OFS_INSTR))
            err_r <= 1'b0;
    end

    // memory request stands for the whole second cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dm_req_r <= '0;
            load_dst_r <= 5'h00;
        end
        else if ((state_r == S_EXEC) && legal && (is_load || is_store))
        begin
            dm_req_r.addr  <= mem_addr;
            dm_req_r.wdata <= rr_val;
            dm_req_r.we    <= is_store;
            dm_req_r.re    <= is_load;
            load_dst_r     <= ir_r.rd;
        end
        else
            dm_req_r <= '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_r <= FLAGS_RESET;
        else if (apb_wr && (addr8 == OFS_STATUS))
            flags_r <= pwdata[7:0];
        else if ((state_r == S_EXEC) && legal)
        begin
            case (ir_r.op)
                OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT:
                begin
                    flags_r[FLAG_C] <= alu_c;
                    flags_r[FLAG_Z] <= alu_z;
                    flags_r[FLAG_N] <= alu_n;
                    flags_r[FLAG_V] <= alu_v;
                end
                OP_FLAG_FORCE_ONE:       flags_r[bsel] <= 1'b1;
                OP_FLAG_FORCE_ZERO:      flags_r[bsel] <= 1'b0;
                OP_BIT_TO_TRANSFER_FLAG: flags_r[FLAG_T] <= rr_val[bsel];
                default:                 flags_r <= flags_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 32; i++)
                rf_r[i] <= 8'h00;
        end
        else if (apb_wr && addr8[7])
            rf_r[addr8[6:2]] <= pwdata[7:0];
        else if ((state_r == S_MEM) && dm_req_r.re)
            rf_r[load_dst_r] <= dm_rdata;
        else if ((state_r == S_EXEC) && legal)
        begin
            if (upd_ptr)
            begin
                rf_r[ptr_lo] <= ptr_nxt[7:0];
                rf_r[ptr_hi] <= ptr_nxt[15:8];
            end
            case (ir_r.op)
                OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_NIBBLE_SWAP, OP_TRANSFER_FLAG_TO_BIT:
                    rf_r[ir_r.rd] <= alu_res;
                OP_REGISTER_COPY:
                    rf_r[ir_r.rd] <= rr_val;
                OP_REGISTER_PAIR_COPY:
                begin
                    rf_r[pair_d]        <= rf_r[pair_s];
                    rf_r[pair_d + 5'd1] <= rf_r[pair_s + 5'd1];
                end
                OP_IMMEDIATE_LOAD:
                    rf_r[ir_r.rd] <= ir_r.k[7:0];
                default:
                    rf_r[ir_r.rd] <= rf_r[ir_r.rd];
            endcase
        end
    end

    // checks
    logic ex;
    logic no_overlap;
    assign ex         = (state_r == S_EXEC) && legal;
    assign no_overlap = (ir_r.rd[4:1] != ptr_lo[4:1]);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence mem_issue;
        ex && (is_load || is_store);
    endsequence

    sequence mem_phase;
        (state_r == S_MEM) && (dm_req_r.re || dm_req_r.we) ##1 (state_r == S_IDLE);
    endsequence

    AST_ROTATE_RESULT: assert property (
        ex && (ir_r.op == OP_ROTATE_RIGHT_CARRY) |=>
        (rd_val == {$past(flags_r[FLAG_C]), $past(rd_val[7:1])}) && (flags_r[FLAG_C] == $past(rd_val[0])))
        else $error("rotate result or carry wrong");

    AST_SHIFT_FLAGS: assert property (
        ex && (ir_r.op == OP_ARITH_SHIFT_RIGHT) |=>
        (rd_val[7:6] == {2{$past(rd_val[7])}}) && (flags_r[FLAG_V] == (flags_r[FLAG_N] ^ flags_r[FLAG_C]))
        && (state_r == S_IDLE))
        else $error("shift right result or flags wrong");

    AST_FLAG_ONE: assert property (
        ex && (ir_r.op == OP_FLAG_FORCE_ONE) |=> flags_r == ($past(flags_r) | (8'h01 << $past(bsel))))
        else $error("flag force-one disturbed other flags");

    AST_FLAG_ZERO: assert property (
        ex && (ir_r.op == OP_FLAG_FORCE_ZERO) |=> flags_r == ($past(flags_r) & ~(8'h01 << $past(bsel))))
        else $error("flag force-zero disturbed other flags");

    AST_TFLAG_STORE: assert property (
        ex && (ir_r.op == OP_BIT_TO_TRANSFER_FLAG) |=>
        (flags_r[FLAG_T] == $past(rr_val[bsel])) && (flags_r[5:0] == $past(flags_r[5:0])))
        else $error("transfer flag copy wrong");

    AST_TFLAG_LOAD: assert property (
        ex && (ir_r.op == OP_TRANSFER_FLAG_TO_BIT) |=> (rd_val[bsel] == $past(flags_r[FLAG_T])) && $stable(flags_r))
        else $error("bit load from transfer flag wrong");

    AST_MEM_TWO_CYCLES: assert property (
        mem_issue |=> mem_phase)
        else $error("memory operation not two cycles");

    AST_LOAD_DATA: assert property (
        (state_r == S_MEM) && dm_req_r.re |=> (rf_r[load_dst_r] == $past(dm_rdata)) && $stable(flags_r))
        else $error("loaded data not written");

    AST_POST_INC: assert property (
        ex && (ir_r.op == OP_POINTER_STORE_INC) |=> (ptr_val == dm_req_r.addr + 16'h0001) && dm_req_r.we)
        else $error("post-increment wrong");

    AST_PRE_DEC: assert property (
        ex && ((ir_r.op == OP_POINTER_LOAD_DEC) || (ir_r.op == OP_POINTER_STORE_DEC)) && no_overlap |=>
        (dm_req_r.addr == $past(ptr_val) - 16'h0001) && (ptr_val == dm_req_r.addr))
        else $error("pre-decrement wrong");

    AST_DISPLACED: assert property (
        ex && (ir_r.op == OP_DISPLACED_POINTER_LOAD) && no_overlap |=>
        (dm_req_r.addr == $past(ptr_val) + {10'h000, $past(ir_r.k[5:0])}) && $stable(ptr_val))
        else $error("displaced address wrong");

    AST_ONE_CYCLE_COPY: assert property (
        ex && ((ir_r.op == OP_NIBBLE_SWAP) || (ir_r.op == OP_REGISTER_COPY) || (ir_r.op == OP_IMMEDIATE_LOAD)
        || (ir_r.op == OP_REGISTER_PAIR_COPY)) |=> (state_r == S_IDLE) && $stable(flags_r))
        else $error("copy took extra cycle or changed flags");
endmodule

// file: exec_pkg.sv
package exec_pkg;

    localparam logic [7:0] OFS_INSTR   = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_RF_BASE = 8'h80;

    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam int BUSY_BIT = 8;
    localparam int ERR_BIT  = 9;

    localparam logic [7:0]  FLAGS_RESET = 8'h00;
    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;

    typedef enum logic [4:0] {
        OP_NOP                    = 5'h00,
        OP_ROTATE_RIGHT_CARRY     = 5'h01,
        OP_ARITH_SHIFT_RIGHT      = 5'h02,
        OP_NIBBLE_SWAP            = 5'h03,
        OP_FLAG_FORCE_ONE         = 5'h04,
        OP_FLAG_FORCE_ZERO        = 5'h05,
        OP_BIT_TO_TRANSFER_FLAG   = 5'h06,
        OP_TRANSFER_FLAG_TO_BIT   = 5'h07,
        OP_REGISTER_COPY          = 5'h08,
        OP_REGISTER_PAIR_COPY     = 5'h09,
        OP_IMMEDIATE_LOAD         = 5'h0A,
        OP_POINTER_LOAD           = 5'h0B,
        OP_POINTER_LOAD_INC       = 5'h0C,
        OP_POINTER_LOAD_DEC       = 5'h0D,
        OP_DISPLACED_POINTER_LOAD = 5'h0E,
        OP_DIRECT_MEMORY_LOAD     = 5'h0F,
        OP_POINTER_STORE          = 5'h10,
        OP_POINTER_STORE_INC      = 5'h11,
        OP_POINTER_STORE_DEC      = 5'h12
    } op_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_EXEC,
        S_MEM
    } exec_state_t;

    typedef struct packed {
        logic [15:0] k;
        logic        spare;
        logic [4:0]  rr;
        logic [4:0]  rd;
        op_t         op;
    } instr_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } dm_req_t;

endpackage

// file: shift_bit_unit.sv
`timescale 1ns/1ps
module shift_bit_unit
    import exec_pkg::*;
(
    input  wire op_t        op,
    input  wire logic [7:0] val,
    input  wire logic [2:0] bsel,
    input  wire logic       cin,
    input  wire logic       tin,
    output logic      [7:0] res,
    output logic            cout,
    output logic            zout,
    output logic            nout,
    output logic            vout
);
    always_comb
    begin
        res  = val;
        cout = cin;
        case (op)
            OP_ROTATE_RIGHT_CARRY:
            begin
                res  = {cin, val[7:1]};
                cout = val[0];
            end
            OP_ARITH_SHIFT_RIGHT:
            begin
                res  = {val[7], val[7:1]};
                cout = val[0];
            end
            OP_NIBBLE_SWAP:          res = {val[3:0], val[7:4]};
            OP_TRANSFER_FLAG_TO_BIT: res[bsel] = tin;
            default:                 res = val;
        endcase
    end

    assign nout = res[7];
    assign zout = (res == 8'h00);
    assign vout = nout ^ cout;
endmodule

// file: data_mem_model.sv
`timescale 1ns/1ps
module data_mem_model
    import exec_pkg::*;
(
    input  wire logic    pclk,
    input  wire dm_req_t dm_req,
    output logic [7:0]   dm_rdata
);
    logic [7:0] mem [65536];
    logic [7:0] noise_r;

    initial
    begin
        noise_r = 8'hA5;
        for (int a = 0; a < 65536; a++)
        begin
            mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5A;
        end
    end

    // read data is only valid while a read is requested, else it changes every cycle
    assign dm_rdata = dm_req.re ? mem[dm_req.addr] : noise_r;

    always @(posedge pclk)
    begin
        noise_r <= ~noise_r;
        if (dm_req.we)
        begin
            mem[dm_req.addr] <= dm_req.wdata;
        end
    end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module tb_top
    import exec_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    dm_req_t     dm_req;
    logic [7:0]  dm_rdata;
    int          mismatches;
    int          cmp_count;

    exec_core #(.PADDR_W(8)) exec_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dm_req(dm_req), .dm_rdata(dm_rdata)
    );

    data_mem_model data_mem_model_inst (.pclk(pclk), .dm_req(dm_req), .dm_rdata(dm_rdata));

    always #20 pclk = ~pclk;

    task automatic conclude();
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            mismatches++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        `CHK(e, 1'b0)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK({e, q}, {1'b0, x})
    endtask

    function automatic logic [7:0] ra(input logic [4:0] n);
        return OFS_RF_BASE + {1'b0, n, 2'b00};
    endfunction

    task automatic setr(input logic [4:0] n, input logic [7:0] v);
        wr(ra(n), {24'h0, v});
    endtask

    task automatic chk_r(input logic [4:0] n, input logic [7:0] v);
        rd_chk(ra(n), {24'h0, v});
    endtask

    task automatic chk_s(input logic [7:0] v);
        rd_chk(OFS_STATUS, {24'h0, v});
    endtask

    task automatic exec(input op_t op, input logic [4:0] rd, input logic [4:0] rr, input logic [15:0] k);
        wr(OFS_INSTR, {k, 1'b0, rr, rd, op});
    endtask

    // memory request must show up in the second cycle after the commit edge
    task automatic mem_op(input op_t op, input logic [4:0] lo, input logic [15:0] p, input logic [15:0] k,
                          input logic [15:0] a, input logic [15:0] pn, input logic store_op);
        logic [7:0] v;
        setr(lo, p[7:0]);
        setr(lo + 5'd1, p[15:8]);
        setr(5'd2, 8'h77);
        wr(OFS_STATUS, 32'h5A);
        v = data_mem_model_inst.mem[a];
        exec(op, store_op ? 5'd0 : 5'd1, 5'd2, k);
        @(posedge pclk);
        `CHK({dm_req.re, dm_req.we}, 2'b00)
        @(posedge pclk);
        `CHK({dm_req.addr, dm_req.we, dm_req.re}, {a, store_op, ~store_op})
        if (store_op)
            `CHK(dm_req.wdata, 8'h77)
        chk_r(lo, pn[7:0]);
        chk_r(lo + 5'd1, pn[15:8]);
        chk_s(8'h5A);
        if (store_op)
            `CHK(data_mem_model_inst.mem[a], 8'h77)
        else
            chk_r(5'd1, v);
    endtask

    op_t        s_op  [4] = '{OP_ROTATE_RIGHT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_ARITH_SHIFT_RIGHT};
    logic [7:0] s_in  [4] = '{8'h81, 8'h01, 8'h81, 8'h02};
    logic       s_cin [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] s_res [4] = '{8'hC0, 8'h00, 8'hC0, 8'h01};

    initial
    begin
        logic [31:0] q;
        logic        e;
        mismatches = 0;
        cmp_count  = 0;
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_s(8'h00);
        chk_r(5'd31, 8'h00);
        apb(1'b0, 8'h08, 32'h0, q, e);
        `CHK({e, q}, {1'b1, 32'h0})
        apb(1'b1, 8'h0C, 32'h0, q, e);
        `CHK(e, 1'b1)
        exec(op_t'(5'h1F), 5'd0, 5'd0, 16'h0);
        rd_chk(OFS_STATUS, 32'h0000_0200);
        for (int i = 0; i < 4; i++)
        begin
            setr(5'd5, s_in[i]);
            wr(OFS_STATUS, {24'h0, 7'h30, s_cin[i]});
            exec(s_op[i], 5'd5, 5'd5, 16'h0);
            chk_r(5'd5, s_res[i]);
            chk_s({4'h6, s_res[i][7] ^ s_in[i][0], s_res[i][7], s_res[i] == 8'h00, s_in[i][0]});
        end
        for (int s = 0; s < 8; s++)
        begin
            wr(OFS_STATUS, 32'h0);
            exec(OP_FLAG_FORCE_ONE, 5'd0, 5'd0, 16'(s));
            chk_s(8'h01 << s);
            wr(OFS_STATUS, 32'hFF);
            exec(OP_FLAG_FORCE_ZERO, 5'd0, 5'd0, 16'(s));
            chk_s(~(8'h01 << s));
        end
        setr(5'd3, 8'h10);
        wr(OFS_STATUS, 32'h0);
        exec(OP_BIT_TO_TRANSFER_FLAG, 5'd3, 5'd3, 16'd4);
        chk_s(8'h40);
        wr(OFS_STATUS, 32'hFF);
        exec(OP_BIT_TO_TRANSFER_FLAG, 5'd3, 5'd3, 16'd3);
        chk_s(8'hBF);
        setr(5'd4, 8'h81);
        wr(OFS_STATUS, 32'h40);
        exec(OP_TRANSFER_FLAG_TO_BIT, 5'd4, 5'd4, 16'd6);
        chk_r(5'd4, 8'hC1);
        chk_s(8'h40);
        wr(OFS_STATUS, 32'hBF);
        exec(OP_TRANSFER_FLAG_TO_BIT, 5'd4, 5'd4, 16'd7);
        chk_r(5'd4, 8'h41);
        chk_s(8'hBF);
        wr(OFS_STATUS, 32'h5A);
        setr(5'd6, 8'h3C);
        exec(OP_NIBBLE_SWAP, 5'd6, 5'd6, 16'h0);
        chk_r(5'd6, 8'hC3);
        exec(OP_REGISTER_COPY, 5'd7, 5'd6, 16'h0);
        chk_r(5'd7, 8'hC3);
        setr(5'd7, 8'h96);
        exec(OP_REGISTER_PAIR_COPY, 5'd8, 5'd6, 16'h0);
        chk_r(5'd8, 8'hC3);
        chk_r(5'd9, 8'h96);
        exec(OP_IMMEDIATE_LOAD, 5'd10, 5'd0, 16'h00A5);
        chk_r(5'd10, 8'hA5);
        chk_s(8'h5A);
        mem_op(OP_POINTER_LOAD_INC, PTR_X_LO, 16'h00FF, 16'h0000, 16'h00FF, 16'h0100, 1'b0);
        mem_op(OP_POINTER_LOAD_DEC, PTR_Y_LO, 16'h0200, 16'h0100, 16'h01FF, 16'h01FF, 1'b0);
        mem_op(OP_DISPLACED_POINTER_LOAD, PTR_Z_LO, 16'h0300, 16'h023F, 16'h033F, 16'h0300, 1'b0);
        mem_op(OP_DISPLACED_POINTER_LOAD, PTR_Y_LO, 16'h0410, 16'h0105, 16'h0415, 16'h0410, 1'b0);
        mem_op(OP_DIRECT_MEMORY_LOAD, PTR_X_LO, 16'h1111, 16'hBEEF, 16'hBEEF, 16'h1111, 1'b0);
        mem_op(OP_POINTER_STORE_INC, PTR_Z_LO, 16'h7FFF, 16'h0200, 16'h7FFF, 16'h8000, 1'b1);
        mem_op(OP_POINTER_STORE_DEC, PTR_X_LO, 16'h1000, 16'h0000, 16'h0FFF, 16'h0FFF, 1'b1);
        conclude();
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        conclude();
    end
endmodule
